// *** hdl/reset_cause_clock_config.sv ***
// Reset cause recording and run-mode clock configuration with register port
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "rc_cfg.svh"
module reset_cause_clock_config #(
	parameter int GATE_W = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic regulatorLossEvt,
	input wire logic softwareEvt,
	input wire logic watchdogEvt,
	input wire logic brownoutEvt,
	input wire logic powerOnEvt,
	input wire logic pinResetEvt,
	input wire logic sleepMode,
	input wire logic deepSleepMode,
	input wire logic [GATE_W-1:0] runGating,
	input wire logic [GATE_W-1:0] sleepGating,
	input wire logic [GATE_W-1:0] deepSleepGating,
	input wire logic [3:0] minimumDivisorLimit,
	output logic [GATE_W-1:0] periphClkEnable,
	output logic sysClkFromOsc,
	output logic sysClkTick,
	output logic pwmClkTick,
	output logic pllPowerDown,
	output logic pllOutputDisable,
	output logic irq
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [5:0] causeFlags_q;
	logic [5:0] causeEvt;
	logic [5:0] irqStatus_q;
	logic [5:0] irqMask_q;
	logic [31:0] config_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic autoSleepGating;
	logic [3:0] systemClockDivisorCode;
	logic dividerSelect;
	logic pwmPrescalerSelect;
	logic [2:0] pwmPrescaleCode;
	logic bypass;
	logic useDivider;
	logic [3:0] effDiv_d;
	logic [3:0] effDiv_q;
	logic [3:0] divCnt_q;
	logic [5:0] pwmCnt_q;
	logic [2:0] pwmShift;
	logic pwmHit;
	logic [5:0] pwmMaskBits;
	logic sysTick_q;
	logic pwmTick_q;
	rc_pkg::gate_sel_t gateSel;
	logic [GATE_W-1:0] periphEn_q;

	assign causeEvt[`RC_CAUSE_REG] = regulatorLossEvt;
	assign causeEvt[`RC_CAUSE_SOFT] = softwareEvt;
	assign causeEvt[`RC_CAUSE_WDOG] = watchdogEvt;
	assign causeEvt[`RC_CAUSE_BROWN] = brownoutEvt;
	assign causeEvt[`RC_CAUSE_POR] = powerOnEvt;
	assign causeEvt[`RC_CAUSE_PIN] = pinResetEvt;

	assign autoSleepGating = config_q[`RC_AUTOGATE_BIT];
	assign systemClockDivisorCode = config_q[`RC_DIV_HI:`RC_DIV_LO];
	assign dividerSelect = config_q[`RC_USEDIV_BIT];
	assign pwmPrescalerSelect = config_q[`RC_USEPWM_BIT];
	assign pwmPrescaleCode = config_q[`RC_PWMCODE_HI:`RC_PWMCODE_LO];
	assign bypass = config_q[`RC_BYPASS_BIT];

	// ----------------------------------------------------------------
	// Reset cause flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			causeFlags_q <= 6'h00;
		end else if (pinResetEvt) begin
			causeFlags_q <= 6'h01;
		end else if (wr && addr == `RC_CAUSE_OFS) begin
			causeFlags_q <= wdata[5:0] | causeEvt;
		end else begin
			causeFlags_q <= causeFlags_q | causeEvt;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqStatus_q <= 6'h00;
		end else if (wr && addr == `RC_IRQ_STAT_OFS) begin
			irqStatus_q <= (irqStatus_q & ~wdata[5:0]) | causeEvt;
		end else begin
			irqStatus_q <= irqStatus_q | causeEvt;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irqMask_q <= 6'h00;
		end else if (wr && addr == `RC_IRQ_MASK_OFS) begin
			irqMask_q <= wdata[5:0];
		end
	end

	assign irq = |(irqStatus_q & irqMask_q);

	// ----------------------------------------------------------------
	// Run clock configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			config_q <= `RC_CONFIG_RESET;
		end else if (wr && addr == `RC_CONFIG_OFS) begin
			config_q <= wdata & `RC_CONFIG_WMASK;
		end
	end

	assign pllPowerDown = config_q[`RC_PWRDN_BIT];
	assign pllOutputDisable = config_q[`RC_OEN_BIT];
	assign sysClkFromOsc = bypass;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h00000000;
		case (addr)
			`RC_CAUSE_OFS: rdata_d = {26'h0000000, causeFlags_q};
			`RC_CONFIG_OFS: rdata_d = config_q;
			`RC_IRQ_STAT_OFS: rdata_d = {26'h0000000, irqStatus_q};
			`RC_IRQ_MASK_OFS: rdata_d = {26'h0000000, irqMask_q};
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	assign rdata = rdata_q;

	// ----------------------------------------------------------------
	// System clock divider
	// ----------------------------------------------------------------
	assign useDivider = dividerSelect | ~bypass;

	always_comb begin
		effDiv_d = systemClockDivisorCode;
		if (effDiv_d == `RC_DIV_RESERVED) begin
			effDiv_d = `RC_DIV_MIN_LEGAL;
		end
		if (!bypass && effDiv_d < minimumDivisorLimit) begin
			effDiv_d = minimumDivisorLimit;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			effDiv_q <= 4'hF;
		end else begin
			effDiv_q <= effDiv_d;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			divCnt_q <= 4'h0;
		end else if (!useDivider || divCnt_q >= effDiv_q) begin
			divCnt_q <= 4'h0;
		end else begin
			divCnt_q <= divCnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sysTick_q <= 1'b0;
		end else begin
			sysTick_q <= !useDivider || divCnt_q >= effDiv_q;
		end
	end

	assign sysClkTick = sysTick_q;

	// ----------------------------------------------------------------
	// PWM prescaler
	// ----------------------------------------------------------------
	assign pwmShift = (pwmPrescaleCode > `RC_PWM_MAX_CODE) ? `RC_PWM_MAX_CODE : pwmPrescaleCode;
	assign pwmMaskBits = 6'(7'h02 << pwmShift) - 6'h01;
	assign pwmHit = (pwmCnt_q & pwmMaskBits) == pwmMaskBits;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pwmCnt_q <= 6'h00;
		end else begin
			pwmCnt_q <= pwmCnt_q + 6'h01;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pwmTick_q <= 1'b0;
		end else begin
			pwmTick_q <= pwmPrescalerSelect ? pwmHit : 1'b1;
		end
	end

	assign pwmClkTick = pwmTick_q;

	// ----------------------------------------------------------------
	// Peripheral clock gating
	// ----------------------------------------------------------------
	always_comb begin
		gateSel = rc_pkg::GATE_RUN;
		if (autoSleepGating && deepSleepMode) begin
			gateSel = rc_pkg::GATE_DEEP;
		end else if (autoSleepGating && sleepMode) begin
			gateSel = rc_pkg::GATE_SLEEP;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periphEn_q <= '0;
		end else begin
			case (gateSel)
				rc_pkg::GATE_SLEEP: periphEn_q <= sleepGating;
				rc_pkg::GATE_DEEP: periphEn_q <= deepSleepGating;
				default: periphEn_q <= runGating;
			endcase
		end
	end

	assign periphClkEnable = periphEn_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_REG_LOSS: assert property (regulatorLossEvt && !pinResetEvt |=> causeFlags_q[5])
		else $error("regulator loss cause not recorded");
	AST_SOFT: assert property (softwareEvt && !pinResetEvt |=> causeFlags_q[4])
		else $error("software cause not recorded");
	AST_WDOG: assert property (watchdogEvt && !pinResetEvt |=> causeFlags_q[3])
		else $error("watchdog cause not recorded");
	AST_BROWN: assert property (brownoutEvt && !pinResetEvt |=> causeFlags_q[2])
		else $error("brownout cause not recorded");
	AST_POR: assert property (powerOnEvt && !pinResetEvt |=> causeFlags_q[1])
		else $error("power-on cause not recorded");
	AST_PIN: assert property (pinResetEvt |=> causeFlags_q == 6'h01)
		else $error("pin reset did not leave only bit 0");
	AST_STICKY: assert property (!pinResetEvt && !wr |=>
		(causeFlags_q & $past(causeFlags_q)) == $past(causeFlags_q))
		else $error("cause bit lost without pin reset");
	AST_GATE: assert property (!reset |=> periphClkEnable == $past(
		(!autoSleepGating || !(sleepMode || deepSleepMode)) ? runGating :
		(deepSleepMode ? deepSleepGating : sleepGating)))
		else $error("peripheral enables from wrong gating source");
	AST_RUN_GATE: assert property (!reset && !sleepMode && !deepSleepMode |=>
		periphClkEnable == $past(runGating))
		else $error("run mode not using run gating");
	AST_NO_AUTO: assert property (!reset && !autoSleepGating |=>
		periphClkEnable == $past(runGating))
		else $error("sleep gating used with auto gating off");
	AST_CLAMP: assert property (!bypass && effDiv_q != 4'h0 |->
		effDiv_q >= $past(minimumDivisorLimit) || $past(bypass) ||
		$past(minimumDivisorLimit) == 4'h0)
		else $error("PLL divisor below minimum");
	AST_DIV_SPACING: assert property (
		useDivider && sysClkTick && $stable(effDiv_q) ##1 useDivider |-> !sysClkTick)
		else $error("divider ticks back to back");
	AST_BYPASS_DIV: assert property (!bypass ##1 !bypass |-> ##1
		!(sysClkTick && $past(sysClkTick) && $past(sysClkTick, 2)))
		else $error("PLL source not divided");
	AST_PWM_OFF: assert property (!reset && !pwmPrescalerSelect |=> pwmClkTick)
		else $error("PWM clock divided while select is off");
	AST_PWM_DIV: assert property (pwmPrescalerSelect && $past(pwmPrescalerSelect) &&
		$stable(pwmShift) && pwmClkTick |=> !pwmClkTick)
		else $error("PWM prescaler ticks back to back");

	COV_PIN: cover property (causeFlags_q[3] ##1 pinResetEvt ##1 causeFlags_q == 6'h01);
	COV_DEEP: cover property (autoSleepGating && deepSleepMode);
	COV_CLAMP: cover property (!bypass && systemClockDivisorCode < minimumDivisorLimit);
	COV_IRQ: cover property (irq);

endmodule : reset_cause_clock_config

// *** hdl/rc_cfg.svh ***
// Register offsets, field positions and reset values for reset cause and clock config
`ifndef RC_CFG_SVH
`define RC_CFG_SVH
`define RC_CAUSE_OFS 12'h05C
`define RC_CONFIG_OFS 12'h060
`define RC_IRQ_STAT_OFS 12'h064
`define RC_IRQ_MASK_OFS 12'h068
`define RC_CAUSE_W 6
`define RC_CAUSE_PIN 0
`define RC_CAUSE_POR 1
`define RC_CAUSE_BROWN 2
`define RC_CAUSE_WDOG 3
`define RC_CAUSE_SOFT 4
`define RC_CAUSE_REG 5
`define RC_AUTOGATE_BIT 27
`define RC_DIV_HI 26
`define RC_DIV_LO 23
`define RC_USEDIV_BIT 22
`define RC_USEPWM_BIT 20
`define RC_PWMCODE_HI 19
`define RC_PWMCODE_LO 17
`define RC_PWRDN_BIT 13
`define RC_OEN_BIT 12
`define RC_BYPASS_BIT 11
`define RC_CONFIG_RESET 32'h078E3800
`define RC_CONFIG_WMASK 32'h0FDE3800
`define RC_PWM_MAX_CODE 3'h5
`define RC_DIV_RESERVED 4'h0
`define RC_DIV_MIN_LEGAL 4'h1
`endif

// *** hdl/rc_pkg.sv ***
// Types shared by the reset cause and clock configuration block
package rc_pkg;
	typedef enum logic [1:0] {
		GATE_RUN = 2'b00,
		GATE_SLEEP = 2'b01,
		GATE_DEEP = 2'b10
	} gate_sel_t;
endpackage : rc_pkg

// *** verification/reset_cause_and_run_clock_config_tb_top.sv ***
// Self-checking testbench for reset cause recording and run clock configuration
`timescale 1ns/1ns
`include "rc_cfg.svh"
module reset_cause_and_run_clock_config_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [5:0] evt = 6'h00;
	logic sleepMode = 1'b0;
	logic deepSleepMode = 1'b0;
	logic [31:0] runGating = 32'h11111111;
	logic [31:0] sleepGating = 32'h22222222;
	logic [31:0] deepSleepGating = 32'h44444444;
	logic [3:0] minimumDivisorLimit = 4'h4;
	logic [31:0] rdata;
	logic [31:0] periphClkEnable;
	logic sysClkFromOsc, sysClkTick, pwmClkTick, pllPowerDown, pllOutputDisable, irq;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int sysCnt, pwmCnt;
	logic [31:0] got;
	logic [5:0] evRow [6] = '{6'h04, 6'h08, 6'h10, 6'h20, 6'h02, 6'h21};
	logic [5:0] causeRow [6] = '{6'h04, 6'h0C, 6'h1C, 6'h3C, 6'h3E, 6'h01};
	logic [31:0] gateCfg [4] = '{32'h08000800, 32'h00000800, 32'h08000800, 32'h08000800};
	logic gateSleep [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	logic gateDeep [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic [31:0] gateExp [4] = '{32'h22222222, 32'h11111111, 32'h11111111, 32'h44444444};
	logic [31:0] clkCfg [5] = '{32'h01C00800, 32'h00900000, 32'h001E0800, 32'h005A0800,
		32'h07960000};
	logic [31:0] sysRow [5] = '{32'd240, 32'd192, 32'd960, 32'd480, 32'd60};
	logic [31:0] pwmRow [5] = '{32'd960, 32'd480, 32'd15, 32'd15, 32'd60};

	reset_cause_clock_config reset_cause_clock_config_i (.clk(clk), .reset(reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .regulatorLossEvt(evt[5]),
		.softwareEvt(evt[4]), .watchdogEvt(evt[3]), .brownoutEvt(evt[2]),
		.powerOnEvt(evt[1]), .pinResetEvt(evt[0]), .sleepMode(sleepMode),
		.deepSleepMode(deepSleepMode), .runGating(runGating), .sleepGating(sleepGating),
		.deepSleepGating(deepSleepGating), .minimumDivisorLimit(minimumDivisorLimit),
		.periphClkEnable(periphClkEnable), .sysClkFromOsc(sysClkFromOsc),
		.sysClkTick(sysClkTick), .pwmClkTick(pwmClkTick), .pllPowerDown(pllPowerDown),
		.pllOutputDisable(pllOutputDisable), .irq(irq));

	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	always #5 clk = ~clk;

	task automatic stop_test();
		if (failures == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[ERR] %0t run did not finish in time", $time);
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : write_reg

	task automatic read_reg(input logic [11:0] a, output logic [31:0] g);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		g = rdata;
	endtask : read_reg

	task automatic pulse(input logic [5:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 6'h00;
	endtask : pulse

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (19) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		chk(periphClkEnable, 32'h0);
		@(posedge clk);
		reset <= 1'b0;
		read_reg(`RC_CONFIG_OFS, got);
		chk(got, `RC_CONFIG_RESET);
		read_reg(`RC_CAUSE_OFS, got);
		chk(got, 32'h0);
		read_reg(12'h100, got);
		chk(got, 32'h0);
		write_reg(`RC_CONFIG_OFS, 32'hFFFFFFFF);
		read_reg(`RC_CONFIG_OFS, got);
		chk(got, 32'h0FDE3800);
		write_reg(`RC_CAUSE_OFS, 32'hFFFFFFFF);
		read_reg(`RC_CAUSE_OFS, got);
		chk(got, 32'h0000003F);
		write_reg(`RC_CAUSE_OFS, 32'h0);
		for (int i = 0; i < 6; i++) begin
			pulse(evRow[i]);
			read_reg(`RC_CAUSE_OFS, got);
			chk(got, {26'h0, causeRow[i]});
		end
		for (int i = 0; i < 4; i++) begin
			write_reg(`RC_CONFIG_OFS, gateCfg[i]);
			sleepMode <= gateSleep[i];
			deepSleepMode <= gateDeep[i];
			repeat (2) @(posedge clk);
			#1;
			chk(periphClkEnable, gateExp[i]);
		end
		@(posedge clk);
		sleepMode <= 1'b0;
		deepSleepMode <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			write_reg(`RC_CONFIG_OFS, clkCfg[i]);
			repeat (4) @(posedge clk);
			sysCnt = 0;
			pwmCnt = 0;
			repeat (960) begin
				@(posedge clk);
				#1;
				sysCnt += (sysClkTick === 1'b1);
				pwmCnt += (pwmClkTick === 1'b1);
			end
			chk(32'(sysCnt), sysRow[i]);
			chk(32'(pwmCnt), pwmRow[i]);
			chk({29'h0, sysClkFromOsc, pllPowerDown, pllOutputDisable},
				{29'h0, clkCfg[i][11], clkCfg[i][13], clkCfg[i][12]});
		end
		write_reg(`RC_IRQ_MASK_OFS, 32'h00000008);
		write_reg(`RC_IRQ_STAT_OFS, 32'h0000003F);
		pulse(6'h08);
		#1;
		chk({31'h0, irq}, 32'h1);
		write_reg(`RC_IRQ_STAT_OFS, 32'h00000008);
		#1;
		chk({31'h0, irq}, 32'h0);
		pulse(6'h10);
		read_reg(`RC_IRQ_STAT_OFS, got);
		chk(got, 32'h00000010);
		chk({31'h0, irq}, 32'h0);
		// ----------------------------------------
		// Reset in mid-run
		// ----------------------------------------
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({26'h0, irq, sysClkTick, pwmClkTick, pllPowerDown, pllOutputDisable, sysClkFromOsc},
			{26'h0, 6'h07});
		chk(periphClkEnable, 32'h0);
		@(posedge clk);
		reset <= 1'b0;
		read_reg(`RC_CAUSE_OFS, got);
		chk(got, 32'h0);
		read_reg(`RC_CONFIG_OFS, got);
		chk(got, `RC_CONFIG_RESET);
		read_reg(`RC_IRQ_STAT_OFS, got);
		chk(got, 32'h0);
		stop_test();
	end
endmodule : reset_cause_and_run_clock_config_tb_top
